// ==== design/adrf_register_file.sv ====
// register file, status flags and serial command port of the converter
// assumes the conversion engine drives EVENTS on CLOCK; serial pins are asynchronous
module adrf_register_file #(
    parameter int PINS = 4
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // serial link
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic RDY_DOUT,
    output logic RDY_DOUT_OE,
    // general pins
    input wire logic [PINS-1:0] GPIO_IN,
    output logic [PINS-1:0] GPIO_OUT,
    output logic [PINS-1:0] GPIO_OE,
    // conversion engine
    input wire adrf_pkg::adrf_event_type EVENTS,
    output adrf_pkg::adrf_control_type CONTROL,
    output adrf_pkg::adrf_command_type COMMAND
);
    // ----------------------------------------
    // pin synchronisation and edges
    // ----------------------------------------
    logic sclk_s, cs_n_s, din_s, sclk_d, rise, fall;
    logic [PINS-1:0] pin_s;

    adrf_sync #(.WIDTH(3 + PINS), .RESET_VALUE({3'h3, {PINS{1'b0}}})) u_sync (
        .clock(CLOCK),
        .resetn(RESETN),
        .async_in({SCLK, CS_N, DIN, GPIO_IN}),
        .sync_out({sclk_s, cs_n_s, din_s, pin_s})
    );

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) sclk_d <= 1'b0;
        else sclk_d <= sclk_s;
    end

    // mode 0 style: sample on rising, shift out on falling
    assign rise = sclk_s & ~sclk_d & ~cs_n_s;
    assign fall = ~sclk_s & sclk_d & ~cs_n_s;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] ctrl_one, pin_reg, gain_cal;
    logic [23:0] data_reg, sys_offset, sys_gain, self_offset, self_gain;
    logic system_gain_overrange_flag, over, under, busy, ready, read_seen;
    logic [2:0] rate;
    logic [7:0] status_byte, pins_read;

    adrf_pkg::adrf_state_type state;
    logic [4:0] bit_cnt, last_bit;
    logic [23:0] shift_in, shift_out, wr_word;
    logic [7:0] cmd;
    logic [3:0] sel;
    logic cmd_done, wr_strobe, data_read_done, sel_word;
    logic [2:0] eoc_cnt;

    assign cmd = {shift_in[6:0], din_s};
    assign wr_word = {shift_in[22:0], din_s};
    assign sel_word = (sel >= adrf_pkg::SEL_DATA) && (sel <= adrf_pkg::SEL_SELF_GAIN);
    assign last_bit = (state == adrf_pkg::ST_CMD || !sel_word) ? adrf_pkg::BYTE_LAST
                                                              : adrf_pkg::WORD_LAST;
    assign cmd_done = rise && state == adrf_pkg::ST_CMD && bit_cnt == adrf_pkg::BYTE_LAST;
    assign wr_strobe = rise && state == adrf_pkg::ST_WRITE && bit_cnt == last_bit;
    assign data_read_done = rise && state == adrf_pkg::ST_READ && bit_cnt == last_bit
                            && sel == adrf_pkg::SEL_DATA;
    assign status_byte = {system_gain_overrange_flag, rate, over, under, busy, ready};

    // input pins read their live level, output pins their stored level
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin_read
            assign pins_read[g] = pin_reg[adrf_pkg::PIN_DIR_LSB + g] ? pin_reg[g] : pin_s[g];
            assign pins_read[adrf_pkg::PIN_DIR_LSB + g] = pin_reg[adrf_pkg::PIN_DIR_LSB + g];
        end
    endgenerate

    function automatic logic [23:0] read_value(input logic [3:0] code);
        unique case (code)
            adrf_pkg::SEL_STATUS: read_value = {status_byte, 16'h0000};
            adrf_pkg::SEL_CTRL_ONE: read_value = {ctrl_one, 16'h0000};
            adrf_pkg::SEL_PINS: read_value = {pins_read, 16'h0000};
            adrf_pkg::SEL_GAIN_CAL: read_value = {gain_cal, 16'h0000};
            adrf_pkg::SEL_DATA: read_value = data_reg;
            adrf_pkg::SEL_SYS_OFFSET: read_value = sys_offset;
            adrf_pkg::SEL_SYS_GAIN: read_value = sys_gain;
            adrf_pkg::SEL_SELF_OFFSET: read_value = self_offset;
            adrf_pkg::SEL_SELF_GAIN: read_value = self_gain;
            default: read_value = 24'h000000;
        endcase
    endfunction

    // ----------------------------------------
    // serial framing
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state <= adrf_pkg::ST_CMD;
            bit_cnt <= 5'h00;
            sel <= 4'h0;
        end else if (cs_n_s) begin
            state <= adrf_pkg::ST_CMD;
            bit_cnt <= 5'h00;
        end else if (rise) begin
            if (bit_cnt != last_bit) begin
                bit_cnt <= bit_cnt + 5'h01;
            end else begin
                bit_cnt <= 5'h00;
                if (state == adrf_pkg::ST_CMD) begin
                    if (cmd[adrf_pkg::CMD_START] && cmd[adrf_pkg::CMD_MODE]
                        && !cmd[adrf_pkg::CMD_ZERO]) begin
                        sel <= cmd[adrf_pkg::CMD_SEL_LSB +: 4];
                        state <= cmd[adrf_pkg::CMD_RW] ? adrf_pkg::ST_READ : adrf_pkg::ST_WRITE;
                    end
                end else begin
                    state <= adrf_pkg::ST_CMD;
                end
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) shift_in <= 24'h000000;
        else if (rise) shift_in <= wr_word;
    end

    // the word is frozen at the command byte, so a result landing mid-read cannot tear it
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            shift_out <= 24'h000000;
        end else if (cmd_done) begin
            shift_out <= read_value(cmd[adrf_pkg::CMD_SEL_LSB +: 4]);
        end else if (fall && state == adrf_pkg::ST_READ) begin
            shift_out <= {shift_out[22:0], 1'b0};
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            COMMAND <= '0;
        end else begin
            COMMAND.valid <= cmd_done && cmd[adrf_pkg::CMD_START] && !cmd[adrf_pkg::CMD_MODE];
            COMMAND.code <= cmd[6:0];
        end
    end

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_one <= adrf_pkg::RST_CTRL_ONE;
            pin_reg <= adrf_pkg::RST_PINS;
            gain_cal <= adrf_pkg::RST_GAIN_CAL;
            sys_offset <= adrf_pkg::RST_WORD;
            sys_gain <= adrf_pkg::RST_WORD;
            self_offset <= adrf_pkg::RST_WORD;
            self_gain <= adrf_pkg::RST_WORD;
        end else if (wr_strobe) begin
            unique case (sel)
                adrf_pkg::SEL_CTRL_ONE: ctrl_one <= wr_word[7:0] & adrf_pkg::CTRL_ONE_MASK;
                adrf_pkg::SEL_PINS: pin_reg <= wr_word[7:0];
                adrf_pkg::SEL_GAIN_CAL: gain_cal <= wr_word[7:0] & adrf_pkg::GAIN_CAL_MASK;
                adrf_pkg::SEL_SYS_OFFSET: sys_offset <= wr_word;
                adrf_pkg::SEL_SYS_GAIN: sys_gain <= wr_word;
                adrf_pkg::SEL_SELF_OFFSET: self_offset <= wr_word;
                adrf_pkg::SEL_SELF_GAIN: self_gain <= wr_word;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            GPIO_OUT <= '0;
            GPIO_OE <= '0;
        end else begin
            GPIO_OUT <= pin_reg[PINS-1:0];
            GPIO_OE <= pin_reg[adrf_pkg::PIN_DIR_LSB +: PINS];
        end
    end

    always_comb begin
        CONTROL.mains_frequency_select = ctrl_one[adrf_pkg::C1_MAINS];
        CONTROL.unipolar = ctrl_one[adrf_pkg::C1_UNIPOLAR];
        CONTROL.external_clock_select = ctrl_one[adrf_pkg::C1_EXTERNAL_CLOCK_SELECT];
        CONTROL.reference_buffer_enable = ctrl_one[adrf_pkg::C1_REFERENCE_BUFFER_ENABLE];
        CONTROL.input_buffer_enable = ctrl_one[adrf_pkg::C1_INPUT_BUFFER_ENABLE];
        CONTROL.offset_binary = ctrl_one[adrf_pkg::C1_FORMAT];
        CONTROL.single_conversion_mode = ctrl_one[adrf_pkg::C1_SINGLE];
        CONTROL.digital_gain_field = gain_cal[7:5];
        CONTROL.skip_system_gain = gain_cal[4];
        CONTROL.skip_system_offset = gain_cal[3];
        CONTROL.skip_self_gain = gain_cal[2];
        CONTROL.skip_self_offset = gain_cal[1];
        CONTROL.system_offset_coefficient = sys_offset;
        CONTROL.system_gain_coefficient = sys_gain;
        CONTROL.self_offset_coefficient = self_offset;
        CONTROL.self_gain_coefficient = self_gain;
    end

    // ----------------------------------------
    // result and status
    // ----------------------------------------
    // results are stored as they come; the first three continuous ones are not marked
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            data_reg <= adrf_pkg::RST_WORD;
            over <= 1'b0;
            under <= 1'b0;
        end else if (EVENTS.result_valid) begin
            data_reg <= {EVENTS.result[15] ^ (ctrl_one[adrf_pkg::C1_FORMAT]
                         & ~ctrl_one[adrf_pkg::C1_UNIPOLAR]), EVENTS.result[14:0], 8'h00};
            over <= EVENTS.over_range;
            under <= EVENTS.under_range;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rate <= adrf_pkg::RST_STATUS[6:4];
            system_gain_overrange_flag <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= EVENTS.busy;
            if (EVENTS.result_valid || EVENTS.cal_done) rate <= EVENTS.rate;
            if (EVENTS.cal_done) system_gain_overrange_flag <= EVENTS.gain_over;
        end
    end

    // a new result always wins over any clear in the same cycle
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ready <= 1'b0;
            read_seen <= 1'b0;
        end else if (EVENTS.result_valid) begin
            ready <= 1'b1;
            read_seen <= 1'b0;
        end else if (data_read_done) begin
            read_seen <= ~EVENTS.busy;
            if (EVENTS.busy) ready <= 1'b0;
        end else if (EVENTS.conv_start) begin
            read_seen <= 1'b0;
            if (read_seen) ready <= 1'b0;
        end
    end

    // ----------------------------------------
    // ready / data pin
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            eoc_cnt <= 3'h0;
        end else if (EVENTS.result_valid && !ctrl_one[adrf_pkg::C1_SINGLE]) begin
            eoc_cnt <= 3'(adrf_pkg::EOC_CYCLES);
        end else if (eoc_cnt != 3'h0) begin
            eoc_cnt <= eoc_cnt - 3'h1;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            RDY_DOUT <= 1'b1;
            RDY_DOUT_OE <= 1'b0;
        end else begin
            RDY_DOUT_OE <= ~cs_n_s;
            if (state == adrf_pkg::ST_READ) begin
                if (fall) RDY_DOUT <= shift_out[23];
            end else begin
                RDY_DOUT <= (eoc_cnt != 3'h0) | ~ready;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    sequence eoc_start;
        EVENTS.result_valid && !ctrl_one[adrf_pkg::C1_SINGLE] ##1 state != adrf_pkg::ST_READ;
    endsequence

    sequence read_of_undefined;
        cmd_done && cmd[adrf_pkg::CMD_START] && cmd[adrf_pkg::CMD_MODE]
            && !cmd[adrf_pkg::CMD_ZERO] && cmd[adrf_pkg::CMD_SEL_LSB +: 4] > 4'h8;
    endsequence

    eoc_pin_rise_a: assert property (eoc_start |=> RDY_DOUT)
        else $error("ready pin did not rise after continuous result");
    undef_read_zero_a: assert property (read_of_undefined |=> shift_out == 24'h000000)
        else $error("undefined register read not zero");
    ready_set_a: assert property (EVENTS.result_valid |=> ready)
        else $error("ready flag not set by new result");
    ready_busy_clear_a: assert property (
        data_read_done && EVENTS.busy && !EVENTS.result_valid |=> !ready)
        else $error("ready flag not cleared after read during conversion");
    ready_unread_hold_a: assert property (
        EVENTS.conv_start && ready && !read_seen && !data_read_done |=> ready)
        else $error("unread result lost its ready flag");
    range_flags_a: assert property (EVENTS.result_valid |=> over == $past(EVENTS.over_range)
        && under == $past(EVENTS.under_range))
        else $error("range flags do not follow result");
    data_write_ignored_a: assert property (
        wr_strobe && sel == adrf_pkg::SEL_DATA && !EVENTS.result_valid |=> $stable(data_reg))
        else $error("result register changed by a write");
    busy_follow_a: assert property (EVENTS.busy |=> busy ##1 status_byte[1] == $past(EVENTS.busy))
        else $error("busy flag does not track modulator");
    gain_over_flag_a: assert property (EVENTS.cal_done && EVENTS.gain_over |=> system_gain_overrange_flag)
        else $error("gain overrange flag not set");
    rate_latch_a: assert property (EVENTS.result_valid |=> rate == $past(EVENTS.rate))
        else $error("rate field not latched with result");
    pin_drive_a: assert property (
        ##1 GPIO_OE == $past(pin_reg[adrf_pkg::PIN_DIR_LSB +: PINS]))
        else $error("pin enable does not follow direction bits");
endmodule // adrf_register_file

// ==== inc/adrf_pkg.sv ====
// constants, field positions and carrier types of the converter register file
// assumes one 20 MHz clock; the conversion engine shares that clock
//
// Summary of operation
// - four-bit select code picks nine registers; codes 0-3 are bytes, 4-8 are words
// - status and result registers are read-only; control and coefficient registers read-write
// - system gain overrange flag set when a system gain calibration overranges
// - status rate field shows rate of held result or of the calibration
// - overrange flag follows each result: set if clipped high, else cleared
// - underrange flag follows each result: set if clipped low, else cleared
// - modulator busy flag high while converting or calibrating, low otherwise
// - result ready flag set when a new result reaches the result register
// - result read outside a conversion clears ready only when the next conversion starts
// - result read during a following conversion clears ready right after the read
// - mains select bit high picks 50Hz rate set, low picks 60Hz set
// - polarity bit high selects unipolar range, low selects bipolar
// - clock select bit high takes external clock, low the internal oscillator
// - reference buffer bit enables buffers; low powers down and bypasses them
// - input buffer bit enables buffers; low powers down and bypasses them
// - bipolar results two's complement when format low, offset binary when high
// - single mode bit high converts once then sleeps; low converts continuously
// - first three continuous results are invalid and left unflagged for host
// - continuous mode signals end of conversion by ready pin rising 0 to 1
// - command byte: start 1, mode 1, zero, four select bits, read/write bit
// - pin direction 0 reads pin level back, 1 drives stored level out
// - writes to the result register are ignored
package adrf_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 50;
    localparam int EOC_HIGH_NS = 200;
    localparam int EOC_CYCLES = (EOC_HIGH_NS + CLK_NS - 1) / CLK_NS;

    // ----------------------------------------
    // register select codes and reset values
    // ----------------------------------------
    localparam logic [3:0] SEL_STATUS = 4'h0;
    localparam logic [3:0] SEL_CTRL_ONE = 4'h1;
    localparam logic [3:0] SEL_PINS = 4'h2;
    localparam logic [3:0] SEL_GAIN_CAL = 4'h3;
    localparam logic [3:0] SEL_DATA = 4'h4;
    localparam logic [3:0] SEL_SYS_OFFSET = 4'h5;
    localparam logic [3:0] SEL_SYS_GAIN = 4'h6;
    localparam logic [3:0] SEL_SELF_OFFSET = 4'h7;
    localparam logic [3:0] SEL_SELF_GAIN = 4'h8;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_CTRL_ONE = 8'h02;
    localparam logic [7:0] RST_PINS = 8'h0F;
    localparam logic [7:0] RST_GAIN_CAL = 8'h1E;
    localparam logic [23:0] RST_WORD = 24'h000000;
    localparam logic [7:0] CTRL_ONE_MASK = 8'hFE;
    localparam logic [7:0] GAIN_CAL_MASK = 8'hFE;

    // ----------------------------------------
    // command byte and control bit fields
    // ----------------------------------------
    localparam int CMD_START = 7;
    localparam int CMD_MODE = 6;
    localparam int CMD_ZERO = 5;
    localparam int CMD_SEL_LSB = 1;
    localparam int CMD_RW = 0;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam logic [4:0] WORD_LAST = 5'h17;
    localparam int C1_MAINS = 7;
    localparam int C1_UNIPOLAR = 6;
    localparam int C1_EXTERNAL_CLOCK_SELECT = 5;
    localparam int C1_REFERENCE_BUFFER_ENABLE = 4;
    localparam int C1_INPUT_BUFFER_ENABLE = 3;
    localparam int C1_FORMAT = 2;
    localparam int C1_SINGLE = 1;
    localparam int PIN_DIR_LSB = 4;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef enum {ST_CMD, ST_WRITE, ST_READ} adrf_state_type;

    typedef struct packed {
        logic conv_start;
        logic busy;
        logic result_valid;
        logic [15:0] result;
        logic over_range;
        logic under_range;
        logic [2:0] rate;
        logic cal_done;
        logic gain_over;
    } adrf_event_type;

    typedef struct packed {
        logic mains_frequency_select;
        logic unipolar;
        logic external_clock_select;
        logic reference_buffer_enable;
        logic input_buffer_enable;
        logic offset_binary;
        logic single_conversion_mode;
        logic [2:0] digital_gain_field;
        logic skip_system_gain;
        logic skip_system_offset;
        logic skip_self_gain;
        logic skip_self_offset;
        logic [23:0] system_offset_coefficient;
        logic [23:0] system_gain_coefficient;
        logic [23:0] self_offset_coefficient;
        logic [23:0] self_gain_coefficient;
    } adrf_control_type;

    typedef struct packed {
        logic valid;
        logic [6:0] code;
    } adrf_command_type;

endpackage

// ==== design/adrf_sync.sv ====
// two-flop synchroniser for a group of pins
// assumes the inputs are asynchronous to clock; reset level is a parameter
module adrf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage <= async_in;
            sync_out <= stage;
        end
    end
endmodule // adrf_sync

// ==== dv/adrf_host.sv ====
// host-side model of the four-wire serial link of the converter register file
// assumes the bench calls its tasks; link idles with select high and serial clock low
module adrf_host (
    // serial link
    input wire logic RDY_DOUT,
    output logic SCLK,
    output logic CS_N,
    output logic DIN
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DIN = 1'b0;
    end

    // select held low between frames lets the end-of-conversion edge be watched
    task automatic select(input logic level);
        CS_N = level;
        #200;
    endtask

    // one frame: command byte, then n data bits out on DIN and in from RDY_DOUT
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int n,
            output logic [23:0] rd);
        rd = '0;
        CS_N = 1'b0;
        #200;
        for (int i = 7; i >= 0; i--) begin
            DIN = cmd[i];
            #200 SCLK = 1'b1;
            #200 SCLK = 1'b0;
        end
        for (int i = n - 1; i >= 0; i--) begin
            DIN = wd[i];
            #200 SCLK = 1'b1;
            // sample late in the high phase: the device shifts only after its synced fall
            #150 rd[i] = RDY_DOUT;
            #50 SCLK = 1'b0;
        end
        // released data line must not keep looking valid
        #200 DIN = ~DIN;
        CS_N = 1'b1;
        #400;
    endtask
endmodule // adrf_host

// ==== dv/adrf_register_file_bench.sv ====
// self-checking bench of the converter register file
// assumes adrf_host as serial partner; bench plays the conversion engine on EVENTS
module adrf_register_file_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic sclk;
    logic cs_n;
    logic din;
    logic rdy_dout;
    logic rdy_oe;
    logic rdy_pin;
    logic [3:0] gpio_in = 4'hF;
    logic [3:0] gpio_out;
    logic [3:0] gpio_oe;
    adrf_pkg::adrf_event_type ev = '0;
    adrf_pkg::adrf_control_type ctl;
    adrf_pkg::adrf_command_type cmd_out;
    logic [7:0] cmd_seen = 8'h00;
    logic [6:0] cmd_code = 7'h00;
    int n_mismatch = 0;
    int total_checks = 0;

    always #25 clock = ~clock;

    adrf_register_file uut (.CLOCK(clock), .RESETN(resetn), .SCLK(sclk), .CS_N(cs_n),
        .DIN(din), .RDY_DOUT(rdy_dout), .RDY_DOUT_OE(rdy_oe), .GPIO_IN(gpio_in),
        .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .EVENTS(ev), .CONTROL(ctl),
        .COMMAND(cmd_out));
    adrf_host host (.RDY_DOUT(rdy_pin), .SCLK(sclk), .CS_N(cs_n), .DIN(din));

    // an undriven pin reads as the inverse, so a late enable cannot pass unseen
    assign rdy_pin = rdy_oe ? rdy_dout : ~rdy_dout;

    // the command pulse stands one cycle only, so it is counted as it comes
    always @(posedge clock) begin
        if (cmd_out.valid) begin
            cmd_seen <= cmd_seen + 8'h01;
            cmd_code <= cmd_out.code;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic int width_of(input logic [3:0] code);
        return (code > 4'h3 && code < 4'h9) ? 24 : 8;
    endfunction

    task automatic wr(input logic [3:0] code, input logic [23:0] val);
        logic [23:0] unused;
        @(posedge clock);
        #5 host.xfer({2'b11, 1'b0, code, 1'b0}, val, width_of(code), unused);
    endtask

    task automatic rdreg(input logic [3:0] code, input logic [23:0] exp, input string name);
        logic [23:0] got;
        @(posedge clock);
        #5 host.xfer({2'b11, 1'b0, code, 1'b1}, 24'h0, width_of(code), got);
        check(name, exp, got);
    endtask

    // one engine step: pulses last a single cycle, levels stay
    task automatic step(input adrf_pkg::adrf_event_type e);
        @(posedge clock) #5 ev = e;
        @(posedge clock) #5 ev.conv_start = 1'b0;
        ev.result_valid = 1'b0;
        ev.cal_done = 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] rst [9];
        rst = '{8'h00, 8'h02, 8'h0F, 8'h1E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        check("gpio_out", 24'hF, {20'h0, gpio_out});
        check("gpio_oe", 24'h0, {20'h0, gpio_oe});
        check("pin enable idle", 24'h0, {23'h0, rdy_oe});
        for (int c = 0; c < 9; c++) begin
            rdreg(4'(c), {16'h0, rst[c]}, "reset value");
        end
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(4'h1, 24'hFD);
        rdreg(4'h1, 24'hFC, "control_one_register");
        check("control bits", 24'h7E, {17'h0, ctl[109 -: 7]});
        wr(4'h1, 24'h04);
        check("control bits", 24'h02, {17'h0, ctl[109 -: 7]});
        wr(4'h3, 24'hE1);
        rdreg(4'h3, 24'hE0, "gain_and_cal_enable_register");
        wr(4'h8, 24'hA5C3E1);
        rdreg(4'h8, 24'hA5C3E1, "self gain");
        check("self gain out", 24'hA5C3E1, ctl.self_gain_coefficient);
        wr(4'h5, 24'h123456);
        rdreg(4'h5, 24'h123456, "sys offset");
        wr(4'h0, 24'hFF);
        wr(4'h4, 24'hFFFFFF);
        wr(4'h9, 24'hFF);
        rdreg(4'h0, 24'h0, "status");
        rdreg(4'h4, 24'h0, "data");
        rdreg(4'h9, 24'h0, "undefined");
        $display("test registers done");
    endtask

    task automatic t_gpio();
        @(posedge clock) #5 gpio_in = 4'b0110;
        wr(4'h2, 24'h95);
        check("gpio_oe", 24'h9, {20'h0, gpio_oe});
        check("gpio_out", 24'h5, {20'h0, gpio_out});
        rdreg(4'h2, 24'h97, "pins");
        $display("test pins done");
    endtask

    task automatic t_events();
        step('{1'b1, 1'b1, 1'b0, 16'h0, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0});
        step('{1'b0, 1'b1, 1'b1, 16'h1234, 1'b1, 1'b0, 3'd5, 1'b0, 1'b0});
        rdreg(4'h0, 24'h5B, "status");
        rdreg(4'h4, 24'h923400, "data");
        rdreg(4'h0, 24'h5A, "status");
        step('{1'b0, 1'b1, 1'b1, 16'h8001, 1'b0, 1'b1, 3'd2, 1'b0, 1'b0});
        rdreg(4'h0, 24'h27, "status");
        step('{1'b0, 1'b0, 1'b0, 16'h8001, 1'b0, 1'b1, 3'd2, 1'b1, 1'b1});
        rdreg(4'h0, 24'hA5, "status");
        rdreg(4'h4, 24'h000100, "data");
        rdreg(4'h0, 24'hA5, "status");
        step('{1'b1, 1'b1, 1'b0, 16'h8001, 1'b0, 1'b1, 3'd2, 1'b0, 1'b1});
        rdreg(4'h0, 24'hA6, "status");
        step('{1'b0, 1'b1, 1'b1, 16'h0002, 1'b0, 1'b0, 3'd3, 1'b0, 1'b0});
        step('{1'b1, 1'b1, 1'b0, 16'h0002, 1'b0, 1'b0, 3'd3, 1'b0, 1'b0});
        rdreg(4'h0, 24'hB3, "status unread");
        $display("test events done");
    endtask

    task automatic t_eoc();
        int k;
        step('{1'b0, 1'b1, 1'b1, 16'h0001, 1'b0, 1'b0, 3'd1, 1'b0, 1'b0});
        #5 host.select(1'b0);
        check("pin enable", 24'h1, {23'h0, rdy_oe});
        check("ready pin low", 24'h0, {23'h0, rdy_pin});
        @(posedge clock) #5 ev.result_valid = 1'b1;
        ev.result = 16'h7FFF;
        @(posedge clock) #5 ev.result_valid = 1'b0;
        k = 0;
        while (rdy_pin !== 1'b1 && k < 8) begin
            @(posedge clock) #5 k++;
        end
        check("end of conversion", 24'h1, {23'h0, rdy_pin});
        rdreg(4'h4, 24'hFFFF00, "data after rise");
        check("pin enable released", 24'h0, {23'h0, rdy_oe});
        $display("test end of conversion done");
    endtask

    // a conversion command is passed on once; a byte without start bit is dropped
    task automatic t_command();
        logic [23:0] unused;
        @(posedge clock);
        #5 host.xfer(8'h83, 24'h0, 0, unused);
        @(posedge clock);
        #5 host.xfer(8'h03, 24'h0, 0, unused);
        check("command pulses", 24'h1, {16'h0, cmd_seen});
        check("command code", 24'h3, {17'h0, cmd_code});
        $display("test command done");
    endtask

    // ----------------------------------------
    // sequence, watchdog and verdict
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        #5 resetn = 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
        t_regs();
        t_gpio();
        t_events();
        t_eoc();
        t_command();
        report_and_stop();
    end

    // about 40 frames of at most 14 us each are expected
    initial begin
        #3000000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // adrf_register_file_bench
